// file: logic/afq_alert_controller.sv
// alert generation: masks, sticky status, per-channel fault queues, fan fault pin, loop pacing
// assumes a byte register port fed by the serial slave and limit flags from the comparators,
// all on the same clock; pins are open drain, driven low while the enable is high
//
// Functional notes
// - a mask bit gates only the alert pin; status still records the fault
// - temperature mask bits 7..0: local hi/lo, remote one hi/lo/diode, remote two hi/lo/diode
// - trip mask: bit 4 on-time percent, bit 3 trip asserted, bit 2 pin state
// - trip pin state mask has no effect in comparator mode
// - fan mask: bit 7 fan one stall, bit 6 alarm speed, bit 5 fan two stall
// - dual-function pin defaults to fan fault output, on any stalled fan
// - configuration four bit 7 turns the pin into trip reference input
// - fault queue filters temperature channels only, and only in latched alert mode
// - each temperature channel counts consecutive out-of-limit readings; fill fires alert
// - queue depth from bits 3:0 by priority: 1, 2, 3 or 4 readings
// - queue counts run independently of status bits
// - queues clear on alert response, first status read, or reset
// - queue clear releases alert; alert returns when a queue refills
// - rate codes 0x00..0x0a give 0.0625 to 64 loops per second
// - averaging only below 16 conversions per second
// - a new rate takes effect when the running loop completes
// - status bits other than the alert bit are sticky until a read or alert response after the condition ends
// - configuration one bit 3: 0 latched alert mode, 1 comparator mode
module afq_alert_controller
  import afq_pkg::*;
#(
  parameter int unsigned SLOWEST_LOOP_CYCLES = 32'(AFQ_SLOWEST_LOOP_CYCLES)
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic [7:0] regWriteData,
  input wire logic regRead,
  output logic [7:0] regReadData,
  input wire logic alertResponseDone,
  input wire logic [7:0] tempOutOfLimit,
  input wire logic [AFQ_CHANNELS-1:0] tempReading,
  input wire logic tripPercentExceeded,
  input wire logic tripAsserted,
  input wire logic thermalTripPinActive,
  input wire logic fanOneStall,
  input wire logic fanAlarmSpeed,
  input wire logic fanTwoStall,
  output logic alertOut,
  output logic alertOe,
  output logic fanFaultOut,
  output logic fanFaultOe,
  output logic thermalTripRefSelect,
  output logic averagingEnable,
  output logic loopStart,
  output logic [3:0] activeRate
);
  import afq_pkg::*;

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------

  // folds the eight temperature sources into {local, remote one, remote two}
  function automatic logic [AFQ_CHANNELS-1:0] afq_channels(input logic [7:0] v);
    afq_channels = {v[7] | v[6], v[5] | v[4] | v[3], v[2] | v[1] | v[0]};
  endfunction

  // priority decode of the queue depth field
  function automatic logic [AFQ_QUEUE_WIDTH-1:0] afq_depth(input logic [3:0] code);
    if (code[3]) begin
      afq_depth = 3'h4;
    end else if (code[2]) begin
      afq_depth = 3'h3;
    end else if (code[1]) begin
      afq_depth = 3'h2;
    end else begin
      afq_depth = 3'h1;
    end
  endfunction

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] configOne;
  logic [7:0] configFour;
  logic [7:0] conversion_rate_select;
  logic [7:0] fault_queue_depth;
  logic [7:0] temperature_alert_mask;
  logic [7:0] trip_alert_mask;
  logic [7:0] fan_alert_mask;
  logic [7:0] statusOne;
  logic [7:0] statusTwo;
  logic [7:0] statusThree;

  logic comparatorMode;
  logic readStatusOne;
  logic readStatusTwo;
  logic readStatusThree;
  logic queueClear;
  logic [7:0] tripLive;
  logic [7:0] fanLive;
  logic [AFQ_CHANNELS-1:0] queueFull;
  logic [AFQ_CHANNELS-1:0] tempLatch;
  logic [AFQ_CHANNELS-1:0] unmaskedChannel;
  logic [AFQ_CHANNELS-1:0] channelOutOfLimit;
  logic [AFQ_QUEUE_WIDTH-1:0] queueDepth;
  logic smbRequest;
  logic compRequest;
  logic [31:0] loopCount;
  logic [31:0] loopPeriod;

  assign comparatorMode = configOne[AFQ_BIT_COMPARATOR_MODE];
  assign readStatusOne = regRead && (regAddr == AFQ_ADDR_STATUS_ONE);
  assign readStatusTwo = regRead && (regAddr == AFQ_ADDR_STATUS_TWO);
  assign readStatusThree = regRead && (regAddr == AFQ_ADDR_STATUS_THREE);
  assign queueClear = alertResponseDone || readStatusOne;
  assign queueDepth = afq_depth(fault_queue_depth[3:0]);

  // live trip and fan sources placed at their status bit positions
  always_comb begin
    tripLive = 8'h00;
    tripLive[AFQ_BIT_TRIP_PERCENT] = tripPercentExceeded;
    tripLive[AFQ_BIT_TRIP_ASSERTED] = tripAsserted;
    tripLive[AFQ_BIT_TRIP_PIN_STATE] = thermalTripPinActive;
    fanLive = 8'h00;
    fanLive[AFQ_BIT_FAN_ONE_STALL] = fanOneStall;
    fanLive[AFQ_BIT_FAN_ALARM] = fanAlarmSpeed;
    fanLive[AFQ_BIT_FAN_TWO_STALL] = fanTwoStall;
  end

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------

  // reserved bits of the trip and fan masks are never stored, so they read zero
  always_ff @(posedge clk) begin
    if (srst) begin
      configOne <= AFQ_RESET_CONFIG;
      configFour <= AFQ_RESET_CONFIG;                    // pin starts as fan fault
      conversion_rate_select <= AFQ_RESET_RATE;
      fault_queue_depth <= AFQ_RESET_QUEUE;
      temperature_alert_mask <= AFQ_RESET_MASK;
      trip_alert_mask <= AFQ_RESET_MASK;
      fan_alert_mask <= AFQ_RESET_MASK;
    end else if (regWrite) begin
      unique case (regAddr)
        AFQ_ADDR_CONFIG_ONE: begin
          configOne <= regWriteData;
        end
        AFQ_ADDR_CONFIG_FOUR: begin
          configFour <= regWriteData;
        end
        AFQ_ADDR_CONVERSION_RATE: begin
          conversion_rate_select <= regWriteData;
        end
        AFQ_ADDR_FAULT_QUEUE: begin
          fault_queue_depth <= regWriteData;
        end
        AFQ_ADDR_TEMP_MASK: begin
          temperature_alert_mask <= regWriteData;
        end
        AFQ_ADDR_TRIP_MASK: begin
          trip_alert_mask <= regWriteData & AFQ_TRIP_MASK_USED;
        end
        AFQ_ADDR_FAN_MASK: begin
          fan_alert_mask <= regWriteData & AFQ_FAN_MASK_USED;
        end
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // register reads
  // ------------------------------------------------------------

  // data is ready the cycle after the read strobe; unmapped offsets read zero
  always_ff @(posedge clk) begin
    if (srst) begin
      regReadData <= 8'h00;
    end else if (regRead) begin
      unique case (regAddr)
        AFQ_ADDR_CONFIG_ONE: regReadData <= configOne;
        AFQ_ADDR_CONFIG_FOUR: regReadData <= configFour;
        AFQ_ADDR_CONVERSION_RATE: regReadData <= conversion_rate_select;
        AFQ_ADDR_FAULT_QUEUE: regReadData <= fault_queue_depth;
        AFQ_ADDR_TEMP_MASK: regReadData <= temperature_alert_mask;
        AFQ_ADDR_TRIP_MASK: regReadData <= trip_alert_mask;
        AFQ_ADDR_FAN_MASK: regReadData <= fan_alert_mask;
        AFQ_ADDR_STATUS_ONE: regReadData <= statusOne;
        AFQ_ADDR_STATUS_TWO: regReadData <= statusTwo;
        AFQ_ADDR_STATUS_THREE: regReadData <= statusThree;
        default: regReadData <= 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // sticky status
  // ------------------------------------------------------------

  // a source that is still out of limit sets its bit again in the clearing cycle, so a
  // read only clears a bit whose condition has gone; masks never touch these bits
  always_ff @(posedge clk) begin
    if (srst) begin
      statusOne <= 8'h00;
      statusTwo <= 8'h00;
    end else begin
      statusOne <= tempOutOfLimit
        | (statusOne & ~{8{readStatusOne || alertResponseDone}});
      statusTwo <= tripLive
        | (statusTwo & ~{8{readStatusTwo || alertResponseDone}});
    end
  end

  // fan bits are sticky, the alert bit mirrors the pin state
  always_ff @(posedge clk) begin
    if (srst) begin
      statusThree <= 8'h00;
    end else begin
      statusThree <= (fanLive
        | (statusThree & AFQ_FAN_MASK_USED & ~{8{readStatusThree || alertResponseDone}}));
      statusThree[AFQ_BIT_ALERT_LOW] <= alertOe;
    end
  end

  // ------------------------------------------------------------
  // fault queues, one per temperature channel
  // ------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < AFQ_CHANNELS; ch++) begin : gQueue
      afq_fault_queue uQueue (
        .clk(clk),
        .srst(srst),
        .queueClear(queueClear),
        .reading(tempReading[ch]),
        .outOfLimit(channelOutOfLimit[ch]),
        .depth(queueDepth),
        .full(queueFull[ch])
      );
    end
  endgenerate

  assign unmaskedChannel = afq_channels(tempOutOfLimit & ~temperature_alert_mask);
  assign channelOutOfLimit = afq_channels(tempOutOfLimit);

  // a channel latches its alert when its queue fills on an unmasked source; a queue clear
  // wins here, otherwise the still-full flag of the clearing cycle would re-arm the latch
  always_ff @(posedge clk) begin
    if (srst) begin
      tempLatch <= '0;
    end else if (queueClear || comparatorMode) begin
      tempLatch <= '0;
    end else begin
      tempLatch <= tempLatch | (queueFull & unmaskedChannel);
    end
  end

  // ------------------------------------------------------------
  // alert request
  // ------------------------------------------------------------

  // latched mode: temperature through the queues, others from sticky status;
  // comparator mode: live unmasked flags, trip pin state excluded
  always_comb begin
    smbRequest = (|tempLatch)
      | (|(statusTwo & AFQ_TRIP_MASK_USED & ~trip_alert_mask))
      | (|(statusThree & AFQ_FAN_MASK_USED & ~fan_alert_mask));
    compRequest = (|(tempOutOfLimit & ~temperature_alert_mask))
      | (tripPercentExceeded & ~trip_alert_mask[AFQ_BIT_TRIP_PERCENT])
      | (tripAsserted & ~trip_alert_mask[AFQ_BIT_TRIP_ASSERTED])
      | (|(fanLive & ~fan_alert_mask));
  end

  // open-drain alert: the level is always low, the enable pulls the line
  always_ff @(posedge clk) begin
    if (srst) begin
      alertOut <= 1'b0;
      alertOe <= 1'b0;
    end else begin
      alertOut <= 1'b0;
      alertOe <= comparatorMode ? compRequest : smbRequest;
    end
  end

  // ------------------------------------------------------------
  // dual-function fan fault pin
  // ------------------------------------------------------------

  // in reference mode the driver is parked so the pin can carry the reference voltage
  always_ff @(posedge clk) begin
    if (srst) begin
      fanFaultOut <= 1'b0;
      fanFaultOe <= 1'b0;
      thermalTripRefSelect <= 1'b0;
    end else begin
      fanFaultOut <= 1'b0;
      fanFaultOe <= !configFour[AFQ_BIT_REF_SELECT] && (fanOneStall || fanTwoStall);
      thermalTripRefSelect <= configFour[AFQ_BIT_REF_SELECT];
    end
  end

  // ------------------------------------------------------------
  // measurement loop pacing
  // ------------------------------------------------------------

  // each code doubles the rate, so the period is the slowest period halved per step
  assign loopPeriod = SLOWEST_LOOP_CYCLES >> activeRate;

  // the rate is only sampled at a loop boundary so a loop never runs at two speeds;
  // the trade-off is a slow loop delays a faster new rate by up to 16 s
  always_ff @(posedge clk) begin
    if (srst) begin
      loopCount <= 32'h0;
      loopStart <= 1'b0;
      activeRate <= AFQ_RESET_RATE[3:0];
    end else if (loopCount >= loopPeriod - 32'h1) begin
      loopCount <= 32'h0;
      loopStart <= 1'b1;
      if (conversion_rate_select > AFQ_RATE_CODE_MAX) begin
        activeRate <= AFQ_RATE_CODE_SLOWEST;
      end else begin
        activeRate <= conversion_rate_select[3:0];
      end
    end else begin
      loopCount <= loopCount + 32'h1;
      loopStart <= 1'b0;
    end
  end

  // averaging follows the rate in force, not the one just written
  always_ff @(posedge clk) begin
    if (srst) begin
      averagingEnable <= 1'b1;
    end else begin
      averagingEnable <= (activeRate < AFQ_RATE_CODE_NO_AVERAGE);
    end
  end

endmodule

// file: include/afq_pkg.sv
// alert mask and fault queue package: register offsets, bit positions, reset values, timing
// assumes a 100 MHz core clock and a byte-wide register port at the printed offsets
package afq_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] AFQ_ADDR_CONFIG_ONE = 8'h01;
  localparam logic [7:0] AFQ_ADDR_CONFIG_FOUR = 8'h04;
  localparam logic [7:0] AFQ_ADDR_CONVERSION_RATE = 8'h05;
  localparam logic [7:0] AFQ_ADDR_FAULT_QUEUE = 8'h06;
  localparam logic [7:0] AFQ_ADDR_TEMP_MASK = 8'h08;
  localparam logic [7:0] AFQ_ADDR_TRIP_MASK = 8'h09;
  localparam logic [7:0] AFQ_ADDR_FAN_MASK = 8'h0a;
  localparam logic [7:0] AFQ_ADDR_STATUS_ONE = 8'h4f;
  localparam logic [7:0] AFQ_ADDR_STATUS_TWO = 8'h50;
  localparam logic [7:0] AFQ_ADDR_STATUS_THREE = 8'h51;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int AFQ_BIT_COMPARATOR_MODE = 3;   // configuration one
  localparam int AFQ_BIT_REF_SELECT = 7;        // configuration four
  localparam int AFQ_BIT_TRIP_PERCENT = 4;      // trip mask and status two
  localparam int AFQ_BIT_TRIP_ASSERTED = 3;
  localparam int AFQ_BIT_TRIP_PIN_STATE = 2;
  localparam int AFQ_BIT_FAN_ONE_STALL = 7;     // fan mask and status three
  localparam int AFQ_BIT_FAN_ALARM = 6;
  localparam int AFQ_BIT_FAN_TWO_STALL = 5;
  localparam int AFQ_BIT_ALERT_LOW = 0;
  localparam logic [7:0] AFQ_TRIP_MASK_USED = 8'h1c;
  localparam logic [7:0] AFQ_FAN_MASK_USED = 8'he0;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] AFQ_RESET_CONFIG = 8'h00;
  localparam logic [7:0] AFQ_RESET_RATE = 8'h07;
  localparam logic [7:0] AFQ_RESET_QUEUE = 8'h00;
  localparam logic [7:0] AFQ_RESET_MASK = 8'h00;

  // ------------------------------------------------------------
  // conversion rate codes and queue depth
  // ------------------------------------------------------------
  localparam logic [7:0] AFQ_RATE_CODE_MAX = 8'h0a;      // 64 per second
  localparam logic [3:0] AFQ_RATE_CODE_SLOWEST = 4'h0;   // 0.0625 per second
  localparam logic [3:0] AFQ_RATE_CODE_NO_AVERAGE = 4'h8; // 16 per second and up
  localparam int AFQ_QUEUE_WIDTH = 3;
  localparam logic [2:0] AFQ_QUEUE_MAX = 3'h4;
  localparam int AFQ_CHANNELS = 3;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam longint AFQ_CLK_PERIOD_NS = 10;
  localparam longint AFQ_SLOWEST_LOOP_MS = 16000;       // one loop per 16 s at code 0x00
  localparam longint AFQ_SLOWEST_LOOP_CYCLES = AFQ_SLOWEST_LOOP_MS * 1000000 / AFQ_CLK_PERIOD_NS;

endpackage

// file: logic/afq_fault_queue.sv
// one temperature channel fault queue: counts consecutive out-of-limit readings
// assumes reading strobes and flags come from the measurement engine on the same clock
module afq_fault_queue
  import afq_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic queueClear,
  input wire logic reading,
  input wire logic outOfLimit,
  input wire logic [AFQ_QUEUE_WIDTH-1:0] depth,
  output logic full
);

  logic [AFQ_QUEUE_WIDTH-1:0] count;
  logic [AFQ_QUEUE_WIDTH-1:0] next_count;

  // ------------------------------------------------------------
  // consecutive count, saturating so a long fault never wraps
  // ------------------------------------------------------------
  always_comb begin
    next_count = count;
    if (queueClear) begin
      next_count = '0;
    end else if (reading) begin
      if (!outOfLimit) begin
        next_count = '0;                                 // an in-limit reading breaks the run
      end else if (count != AFQ_QUEUE_MAX) begin
        next_count = count + 3'h1;
      end
    end
  end

  // counter and fill flag, independent of any status bit
  always_ff @(posedge clk) begin
    if (srst) begin
      count <= '0;
      full <= 1'b0;
    end else begin
      count <= next_count;
      full <= (next_count != '0) && (next_count >= depth);
    end
  end

endmodule

// file: bench/afq_alert_controller_asserts.sv
// port checker for the alert controller
// assumes it is bound into every controller instance
module afq_alert_controller_chk
  import afq_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic fanOneStall,
  input wire logic fanTwoStall,
  input wire logic alertOe,
  input wire logic fanFaultOe,
  input wire logic thermalTripRefSelect,
  input wire logic averagingEnable,
  input wire logic loopStart,
  input wire logic [3:0] activeRate
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // assertions
  // ----
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  chk_reset_state:
    assert property ($past(srst) |-> !alertOe && !loopStart && activeRate == 4'h7) else $error("bad reset state");
  // stable select only, though fanFaultOe and the select update on the same edge
  chk_fan_pin:
    assert property (!$past(srst) && $stable(thermalTripRefSelect)
      |-> fanFaultOe == (!thermalTripRefSelect && $past(fanOneStall || fanTwoStall))) else $error("fan pin wrong");
  chk_ref_quiet:
    assert property (thermalTripRefSelect && $past(thermalTripRefSelect) |-> !fanFaultOe) else $error("ref pin driven");
  chk_ref_cause:
    assert property ($changed(thermalTripRefSelect) |-> $past(regWrite && regAddr == AFQ_ADDR_CONFIG_FOUR)
      || $past(regWrite && regAddr == AFQ_ADDR_CONFIG_FOUR, 2)) else $error("ref select moved alone");
  chk_avg_rate:
    assert property ($stable(activeRate) |-> averagingEnable == (activeRate < 4'h8)) else $error("averaging wrong");
  chk_rate_boundary:
    assert property ($changed(activeRate) |-> loopStart) else $error("rate changed mid loop");
  chk_loop_gap:
    assert property (loopStart |=> !loopStart [*3]) else $error("loop too short");
  chk_rate_range:
    assert property (activeRate <= 4'ha) else $error("rate out of range");
  // main scenarios reached
  cover property (loopStart && activeRate == 4'ha);
  cover property (fanFaultOe);
  cover property (alertOe);
endmodule

bind afq_alert_controller afq_alert_controller_chk i_chk (
  .clk, .srst, .regAddr, .regWrite, .fanOneStall, .fanTwoStall, .alertOe, .fanFaultOe,
  .thermalTripRefSelect, .averagingEnable, .loopStart, .activeRate
);

// file: bench/afq_host_model.sv
// host side of the register port: byte writes, reads and alert responses
// assumes the controller samples its port on the rising clock edge
module afq_host_model
  import afq_pkg::*;
(
  input wire logic clk,
  output logic [7:0] regAddr,
  output logic regWrite,
  output logic [7:0] regWriteData,
  output logic regRead,
  input wire logic [7:0] regReadData,
  output logic alertResponseDone
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // transfers
  // ----
  // idle levels from time zero
  initial {regAddr, regWrite, regWriteData, regRead, alertResponseDone} = '0;
  // data is inverted after a write so nothing can lean on a stale byte
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    #1;
    regAddr = a;
    regWriteData = v;
    regWrite = 1'b1;
    @(posedge clk);
    #1;
    regWrite = 1'b0;
    regWriteData = ~v;
  endtask
  // status reads find the alert source and clear what has gone
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    #1;
    regAddr = a;
    regRead = 1'b1;
    @(posedge clk);
    #1;
    regRead = 1'b0;
    v = regReadData;
  endtask
  // completed alert response transaction
  task automatic ara();
    @(posedge clk);
    #1;
    alertResponseDone = 1'b1;
    @(posedge clk);
    #1;
    alertResponseDone = 1'b0;
  endtask
endmodule

// file: bench/afq_alert_controller_tb_top.sv
// self-checking bench for the alert controller
// assumes the host model owns the register port; the bench drives every limit flag
module afq_alert_controller_tb_top
  import afq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned LOOP_CYCLES = 4096; // short slowest loop keeps rate tests brief
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] tempOutOfLimit = 8'h00;
  logic [2:0] tempReading = 3'h0;
  logic tripPercentExceeded = 1'b0;
  logic tripAsserted = 1'b0;
  logic thermalTripPinActive = 1'b0;
  logic fanOneStall = 1'b0;
  logic fanAlarmSpeed = 1'b0;
  logic fanTwoStall = 1'b0;
  logic [7:0] regAddr, regWriteData, regReadData, d;
  logic regWrite, regRead, alertResponseDone, alertOut, alertOe, fanFaultOut, fanFaultOe;
  logic thermalTripRefSelect, averagingEnable, loopStart;
  logic [3:0] activeRate;
  int failures = 0;
  int nTests = 0;
  int cycles = 0;
  // ----
  // harness
  // ----
  always #5 clk = ~clk;
  afq_host_model i_host (.clk, .regAddr, .regWrite, .regWriteData, .regRead, .regReadData, .alertResponseDone);
  afq_alert_controller #(.SLOWEST_LOOP_CYCLES(LOOP_CYCLES)) i_dut (
    .clk, .srst, .regAddr, .regWrite, .regWriteData, .regRead, .regReadData, .alertResponseDone,
    .tempOutOfLimit, .tempReading, .tripPercentExceeded, .tripAsserted, .thermalTripPinActive,
    .fanOneStall, .fanAlarmSpeed, .fanTwoStall, .alertOut, .alertOe, .fanFaultOut, .fanFaultOe,
    .thermalTripRefSelect, .averagingEnable, .loopStart, .activeRate
  );
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    nTests++;
    if (seen !== want) begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, seen, want);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one reading strobe on channel ch
  task automatic pulse(input int ch);
    tick(1);
    tempReading[ch] = 1'b1;
    tick(1);
    tempReading = 3'h0;
  endtask
  // bounded wait for a loop boundary; a miss shows up in the next compare
  task automatic wait_loop();
    int n;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (loopStart !== 1'b1 && n < 5000);
  endtask
  task automatic wrap_up();
    if (failures == 0 && nTests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic sc_reset();
    logic [7:0] a [5] = '{AFQ_ADDR_FAULT_QUEUE, AFQ_ADDR_TEMP_MASK, AFQ_ADDR_TRIP_MASK, AFQ_ADDR_FAN_MASK, 8'h30};
    i_host.rd(AFQ_ADDR_CONVERSION_RATE, d);
    check(d, 8'h07);
    foreach (a[i]) begin
      i_host.rd(a[i], d);
      check(d, 8'h00);
    end
  endtask
  task automatic sc_masks();
    logic [7:0] a [3] = '{AFQ_ADDR_TEMP_MASK, AFQ_ADDR_TRIP_MASK, AFQ_ADDR_FAN_MASK};
    logic [7:0] w [3] = '{8'hff, 8'h1c, 8'he0};
    foreach (a[i]) begin
      i_host.wr(a[i], 8'hff);
      i_host.rd(a[i], d);
      check(d, w[i]);
      i_host.wr(a[i], 8'h00);
    end
  endtask
  // every depth pattern with its don't-care bits set; clears alternate
  task automatic sc_queue();
    logic [7:0] c [4] = '{8'h01, 8'h03, 8'h07, 8'h0f};
    foreach (c[i]) begin
      i_host.wr(AFQ_ADDR_FAULT_QUEUE, c[i]);
      tempOutOfLimit = 8'h80;
      for (int k = 0; k <= i; k++) begin
        pulse(2);
        tick(3);
        check(alertOe, k == i);
      end
      if (i % 2 == 1) begin
        i_host.ara();
      end else begin
        i_host.rd(AFQ_ADDR_STATUS_ONE, d);
        check(d, 8'h80);
      end
      tick(2);
      check(alertOe, 1'b0);
      tempOutOfLimit = 8'h00;
      i_host.rd(AFQ_ADDR_STATUS_ONE, d);
    end
  endtask
  task automatic sc_consec();
    i_host.wr(AFQ_ADDR_FAULT_QUEUE, 8'h02);
    tempOutOfLimit = 8'h20;
    pulse(1);
    tempOutOfLimit = 8'h00;
    pulse(1);
    tempOutOfLimit = 8'h20;
    pulse(1);
    tick(3);
    check(alertOe, 1'b0);
    i_host.rd(AFQ_ADDR_STATUS_TWO, d);
    pulse(1);
    tick(3);
    check(alertOe, 1'b1);
    tempOutOfLimit = 8'h00;
    i_host.rd(AFQ_ADDR_STATUS_ONE, d);
    check(d, 8'h20);
    tick(2);
    check(alertOe, 1'b0);
  endtask
  // host masks the source, services it, polls status, then unmasks
  task automatic sc_mask();
    i_host.wr(AFQ_ADDR_FAULT_QUEUE, 8'h00);
    i_host.wr(AFQ_ADDR_TEMP_MASK, 8'h80);
    tempOutOfLimit = 8'h80;
    pulse(2);
    tick(3);
    check(alertOe, 1'b0);
    tempOutOfLimit = 8'h00;
    i_host.rd(AFQ_ADDR_STATUS_ONE, d);
    check(d, 8'h80);
    i_host.rd(AFQ_ADDR_STATUS_ONE, d);
    check(d, 8'h00);
    i_host.wr(AFQ_ADDR_TEMP_MASK, 8'h00);
  endtask
  task automatic sc_fan();
    i_host.wr(AFQ_ADDR_FAN_MASK, 8'h80);
    fanOneStall = 1'b1;
    tick(2);
    check({alertOe, fanFaultOe}, 2'b01);
    i_host.wr(AFQ_ADDR_CONFIG_FOUR, 8'h80);
    tick(2);
    check({thermalTripRefSelect, fanFaultOe}, 2'b10);
    i_host.wr(AFQ_ADDR_CONFIG_FOUR, 8'h00);
    fanOneStall = 1'b0;
    fanTwoStall = 1'b1;
    tick(2);
    check({alertOe, fanFaultOe, alertOut, fanFaultOut}, 4'hc);
    fanTwoStall = 1'b0;
    i_host.rd(AFQ_ADDR_STATUS_THREE, d);
    check(d, 8'ha1);
    tick(2);
    check(alertOe, 1'b0);
    i_host.wr(AFQ_ADDR_FAN_MASK, 8'h00);
  endtask
  // deepest queue set, yet comparator mode must alert without any reading
  task automatic sc_comp();
    i_host.wr(AFQ_ADDR_CONFIG_ONE, 8'h08);
    i_host.wr(AFQ_ADDR_FAULT_QUEUE, 8'h08);
    thermalTripPinActive = 1'b1;
    tick(2);
    check(alertOe, 1'b0);
    tempOutOfLimit = 8'h20;
    tick(2);
    check(alertOe, 1'b1);
    tempOutOfLimit = 8'h00;
    tick(2);
    check(alertOe, 1'b0);
    thermalTripPinActive = 1'b0;
    i_host.rd(AFQ_ADDR_STATUS_TWO, d);
    check(d, 8'h04);
    i_host.rd(AFQ_ADDR_STATUS_ONE, d);
    i_host.wr(AFQ_ADDR_CONFIG_ONE, 8'h00);
  endtask
  // masked trip percent stays quiet; trip asserted and alarm speed alert, then clear on read
  task automatic sc_trip();
    i_host.wr(AFQ_ADDR_TRIP_MASK, 8'h10);
    tripPercentExceeded = 1'b1;
    tick(2);
    check(alertOe, 1'b0);
    tripAsserted = 1'b1;
    fanAlarmSpeed = 1'b1;
    tick(2);
    check(alertOe, 1'b1);
    {tripPercentExceeded, tripAsserted, fanAlarmSpeed} = 3'h0;
    i_host.rd(AFQ_ADDR_STATUS_TWO, d);
    check(d, 8'h18);
    i_host.rd(AFQ_ADDR_STATUS_THREE, d);
    check(d, 8'h41);
    tick(2);
    check(alertOe, 1'b0);
    i_host.wr(AFQ_ADDR_TRIP_MASK, 8'h00);
  endtask
  task automatic sc_rate();
    logic [7:0] c [3] = '{8'h0b, 8'h0a, 8'h08};
    logic [3:0] w [3] = '{4'h0, 4'ha, 4'h8};
    foreach (c[i]) begin
      wait_loop();
      i_host.wr(AFQ_ADDR_CONVERSION_RATE, c[i]);
      check(activeRate, i == 0 ? 4'h7 : w[i - 1]);
      wait_loop();
      check(activeRate, w[i]);
      tick(1);
      check(averagingEnable, w[i] < 4'h8);
    end
  endtask
  // ----
  // run control
  // ----
  initial begin
    repeat (4) @(posedge clk);
    #1;
    srst = 1'b0;
    sc_reset();
    sc_masks();
    sc_queue();
    sc_consec();
    sc_mask();
    sc_fan();
    sc_comp();
    sc_trip();
    sc_rate();
    wrap_up();
  end
  // ceiling well above the two slowest loops the rate test waits through
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      wrap_up();
    end
  end
endmodule
